// ==== hdl/eivr_cfg.svh ====
`ifndef EIVR_CFG_SVH
`define EIVR_CFG_SVH

// ======================================================================
// register indices (byte address is four times the index)
`define EIVR_IDX_MCU      8'h35
`define EIVR_IDX_FLAGS    8'h3c
`define EIVR_IDX_MASK     8'h3d
`define EIVR_IDX_SENSE    8'h69
`define EIVR_IDX_VBASE    8'h75

// ======================================================================
// mcu_control field positions
`define EIVR_MCU_VCE      0
`define EIVR_MCU_VSEL     1
`define EIVR_MCU_PULLOFF  4
`define EIVR_MCU_FLASHPD  6
`define EIVR_MCU_FASTWK   7

// ======================================================================
// sense control field positions
`define EIVR_SNS_A_LSB    0
`define EIVR_SNS_B_LSB    2

// ======================================================================
// reset values and timing
`define EIVR_RST_BYTE     8'h00
`define EIVR_RST_VEC      16'h0000
`define EIVR_VCE_WIN      3'h6
`define EIVR_BASE_SHIFT   8

`endif

// ==== hdl/eivr_pkg.sv ====
package eivr_pkg;

   // ===================================================================
   // trigger selection per pin
   typedef enum logic [1:0] {
      EIVR_SNS_LOW,
      EIVR_SNS_ANY,
      EIVR_SNS_FALL,
      EIVR_SNS_RISE
   } eivr_sense_t;

   // ===================================================================
   // whole block state
   typedef struct packed {
      logic        fast_wake_en;
      logic        flash_powerdown_en;
      logic        pullup_global_off;
      logic        vector_select;
      logic        vector_change_enable;
      logic [2:0]  win_cnt;
      logic [1:0]  ext_irq_flags;
      logic [1:0]  ext_irq_mask;
      logic [3:0]  ext_irq_sense_ctrl;
      logic [7:0]  vector_base;
      logic [2:0]  sync_a;
      logic [2:0]  sync_b;
      logic [1:0]  pin_lvl;
      logic [31:0] prdata;
      logic        perr;
      logic [15:0] vec_addr;
   } eivr_state_t;

endpackage : eivr_pkg

// ==== hdl/eivr_top.sv ====
// Added by the designer: the APB slave port.
`timescale 1ns/1ps
`include "eivr_cfg.svh"

// What this block does
// - reset vector always at address zero
// - selected vectors relocate to 256-byte page
// - select changes only within enable window
// - relocated address is base shl 8 plus default
// - pull-off bit4, select bit1, enable bit0
// - flash power-down bit6, fast wake bit7
// - pins trigger even when driven as outputs
// - sense codes: low, any, fall, rise
// - low level requests while pin stays low
// - edges and low level request clocked, low level wake detected asynchronously
// - only low level wakes from deep sleep
// - sampled edges, pulses of two cycles or more caught
// - request needs global enable and mask bit
// - sense fields bits 3:2 and 1:0
// - mask, flags and sense at their offsets
// - sense 3 is rising edge on pin a
// - flags set by edges, cleared vectoring or w1c
// - mask bits gate interrupt and wake per pin
module eivr_top
   import eivr_pkg::*;
#(
   parameter int ADDR_W = 12
)
(
   input  wire logic              mclk,
   input  wire logic              rst,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic              ext_irq_pin_a,
   input  wire logic              ext_irq_pin_b,
   input  wire logic              global_irq_en,
   input  wire logic              irq_ack_a,
   input  wire logic              irq_ack_b,
   output logic                   irq_req_a,
   output logic                   irq_req_b,
   output logic                   wake_req,
   input  wire logic [15:0]       vec_default_addr,
   output logic      [15:0]       vec_addr,
   output logic                   pullup_global_off,
   output logic                   flash_powerdown_en,
   output logic                   fast_wake_en
);

   // ===================================================================
   // state
   eivr_state_t st_ff;
   eivr_state_t nxt_st;

   logic        setup_ph;
   logic        wr_acc;
   logic        hit_mcu;
   logic        hit_flags;
   logic        hit_mask;
   logic        hit_sense;
   logic        hit_vbase;
   logic        addr_ok;
   logic [7:0]  rd_byte;
   logic [7:0]  wbyte;
   logic [1:0]  pins_raw;
   logic [1:0]  stable;
   logic [1:0]  new_lvl;
   logic [1:0]  edge_hit;
   logic [1:0]  low_req;
   logic [1:0]  low_async;
   logic [1:0]  ack;
   logic [1:0]  irq_vec;
   logic [15:0] reloc_addr;

   // ===================================================================
   // apb decode
   function automatic logic idx_hit(input logic [ADDR_W-1:0] a,
                                    input logic [7:0] idx);
      idx_hit = (a[1:0] == 2'h0) && (a[ADDR_W-1:2] == (ADDR_W-2)'(idx));
   endfunction : idx_hit

   assign setup_ph  = psel && !penable;
   assign wr_acc    = psel && penable && pwrite;
   assign wbyte     = pwdata[7:0];
   assign hit_mcu   = idx_hit(paddr, `EIVR_IDX_MCU);
   assign hit_flags = idx_hit(paddr, `EIVR_IDX_FLAGS);
   assign hit_mask  = idx_hit(paddr, `EIVR_IDX_MASK);
   assign hit_sense = idx_hit(paddr, `EIVR_IDX_SENSE);
   assign hit_vbase = idx_hit(paddr, `EIVR_IDX_VBASE);
   assign addr_ok   = hit_mcu || hit_flags || hit_mask || hit_sense ||
                      hit_vbase;

   // reserved bits read zero
   always_comb
   begin
      rd_byte = `EIVR_RST_BYTE;
      if (hit_mcu)
      begin
         rd_byte[`EIVR_MCU_FASTWK]  = st_ff.fast_wake_en;
         rd_byte[`EIVR_MCU_FLASHPD] = st_ff.flash_powerdown_en;
         rd_byte[`EIVR_MCU_PULLOFF] = st_ff.pullup_global_off;
         rd_byte[`EIVR_MCU_VSEL]    = st_ff.vector_select;
         rd_byte[`EIVR_MCU_VCE]     = st_ff.vector_change_enable;
      end
      else if (hit_flags)
         rd_byte[1:0] = st_ff.ext_irq_flags;
      else if (hit_mask)
         rd_byte[1:0] = st_ff.ext_irq_mask;
      else if (hit_sense)
         rd_byte[3:0] = st_ff.ext_irq_sense_ctrl;
      else if (hit_vbase)
         rd_byte = st_ff.vector_base;
   end

   // ===================================================================
   // pin detection, one lane per pin
   assign pins_raw = {ext_irq_pin_b, ext_irq_pin_a};
   assign ack      = {irq_ack_b, irq_ack_a};

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++)
      begin : g_pin
         logic [2:0]  sy;
         eivr_sense_t mode;
         logic        edge_l;
         assign sy   = (gi == 0) ? st_ff.sync_a : st_ff.sync_b;
         assign mode = eivr_sense_t'(st_ff.ext_irq_sense_ctrl[2*gi +: 2]);
         // a level is taken once the two late stages agree
         assign stable[gi]  = (sy[1] == sy[2]);
         assign new_lvl[gi] = stable[gi] ? sy[2] : st_ff.pin_lvl[gi];
         // lane-local result so no two processes share one vector
         always_comb
         begin
            case (mode)
               EIVR_SNS_ANY:
                  edge_l = new_lvl[gi] != st_ff.pin_lvl[gi];
               EIVR_SNS_FALL:
                  edge_l = st_ff.pin_lvl[gi] && !new_lvl[gi];
               EIVR_SNS_RISE:
                  edge_l = !st_ff.pin_lvl[gi] && new_lvl[gi];
               default:
                  edge_l = 1'b0;
            endcase
         end
         assign edge_hit[gi] = edge_l;
         assign low_req[gi] = (mode == EIVR_SNS_LOW) &&
                              !st_ff.pin_lvl[gi];
         // no clock in this path so it works while the io clock sleeps
         assign low_async[gi] = (mode == EIVR_SNS_LOW) &&
                                !pins_raw[gi] &&
                                st_ff.ext_irq_mask[gi];
         assign irq_vec[gi] = global_irq_en && st_ff.ext_irq_mask[gi] &&
                              (st_ff.ext_irq_flags[gi] ||
                               low_req[gi]);
      end
   endgenerate

   // ===================================================================
   // vector relocation
   assign reloc_addr = (16'(st_ff.vector_base) << `EIVR_BASE_SHIFT) +
                       vec_default_addr;

   // ===================================================================
   // next state
   always_comb
   begin
      nxt_st = st_ff;
      nxt_st.sync_a  = {st_ff.sync_a[1:0], ext_irq_pin_a};
      nxt_st.sync_b  = {st_ff.sync_b[1:0], ext_irq_pin_b};
      nxt_st.pin_lvl = new_lvl;

      // edge set beats any clear in the same cycle
      for (int i = 0; i < 2; i++)
      begin
         if (ack[i] || (wr_acc && hit_flags && wbyte[i]))
            nxt_st.ext_irq_flags[i] = 1'b0;
         if (edge_hit[i])
            nxt_st.ext_irq_flags[i] = 1'b1;
      end

      // window shrinks each cycle, enable drops when it runs out
      if (st_ff.win_cnt != 3'h0)
         nxt_st.win_cnt = st_ff.win_cnt - 3'h1;
      if (st_ff.win_cnt == 3'h1)
         nxt_st.vector_change_enable = 1'b0;

      if (wr_acc && hit_mcu)
      begin
         nxt_st.fast_wake_en       = wbyte[`EIVR_MCU_FASTWK];
         nxt_st.flash_powerdown_en = wbyte[`EIVR_MCU_FLASHPD];
         nxt_st.pullup_global_off  = wbyte[`EIVR_MCU_PULLOFF];
         if (wbyte[`EIVR_MCU_VCE])
         begin
            nxt_st.vector_change_enable = 1'b1;
            nxt_st.win_cnt = `EIVR_VCE_WIN;
         end
         else if (st_ff.win_cnt != 3'h0)
         begin
            // select only moves inside the open window
            nxt_st.vector_select = wbyte[`EIVR_MCU_VSEL];
            nxt_st.vector_change_enable = 1'b0;
            nxt_st.win_cnt = 3'h0;
         end
      end
      if (wr_acc && hit_mask)
         nxt_st.ext_irq_mask = wbyte[1:0];
      if (wr_acc && hit_sense)
         nxt_st.ext_irq_sense_ctrl = wbyte[3:0];
      if (wr_acc && hit_vbase)
         nxt_st.vector_base = wbyte;

      if (setup_ph)
      begin
         nxt_st.prdata = {24'h000000, rd_byte};
         nxt_st.perr   = !addr_ok;
      end

      // reset vector is never relocated
      if (vec_default_addr == `EIVR_RST_VEC)
         nxt_st.vec_addr = `EIVR_RST_VEC;
      else if (st_ff.vector_select)
         nxt_st.vec_addr = reloc_addr;
      else
         nxt_st.vec_addr = vec_default_addr;
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         st_ff <= '0;
         st_ff.sync_a  <= 3'h7;
         st_ff.sync_b  <= 3'h7;
         st_ff.pin_lvl <= 2'h3;
      end
      else
         st_ff <= nxt_st;
   end

   // ===================================================================
   // outputs
   assign prdata             = st_ff.prdata;
   assign pready             = 1'b1;
   assign pslverr            = st_ff.perr;
   assign irq_req_a          = irq_vec[0];
   assign irq_req_b          = irq_vec[1];
   assign wake_req           = |low_async;
   assign vec_addr           = st_ff.vec_addr;
   assign pullup_global_off  = st_ff.pullup_global_off;
   assign flash_powerdown_en = st_ff.flash_powerdown_en;
   assign fast_wake_en       = st_ff.fast_wake_en;

   // ===================================================================
   // checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   a_reset_vec_zero: assert property (
      (vec_default_addr == 16'h0000) |=> (vec_addr == 16'h0000))
      else $error("reset vector relocated");

   a_reloc_addr_calc: assert property (
      (st_ff.vector_select && vec_default_addr != 16'h0000) |=>
      (vec_addr == $past({st_ff.vector_base, 8'h00} + vec_default_addr)))
      else $error("relocated vector address wrong");

   a_vsel_locked: assert property (
      (st_ff.win_cnt == 3'h0) |=>
      (st_ff.vector_select == $past(st_ff.vector_select)))
      else $error("select moved outside window");

   a_vce_expires: assert property (
      (st_ff.win_cnt == 3'h1 && !(wr_acc && hit_mcu)) |=>
      !st_ff.vector_change_enable ##1
      (!st_ff.vector_change_enable || $past(wr_acc && hit_mcu)))
      else $error("change enable outlived window");

   a_edge_sets_flag: assert property (
      edge_hit[0] |=> st_ff.ext_irq_flags[0])
      else $error("edge did not set flag a");

   a_low_no_flag: assert property (
      (st_ff.ext_irq_sense_ctrl[1:0] == 2'h0 && !st_ff.ext_irq_flags[0] &&
       !(wr_acc && hit_sense)) |=> !st_ff.ext_irq_flags[0])
      else $error("low level set flag a");

   a_irq_gated: assert property (
      (irq_req_a || irq_req_b) |->
      (global_irq_en && st_ff.ext_irq_mask != 2'h0))
      else $error("request without enables");

   a_level_request: assert property (
      (st_ff.ext_irq_sense_ctrl[3:2] == 2'h0 && st_ff.ext_irq_mask[1] &&
       global_irq_en && !st_ff.pin_lvl[1]) |-> irq_req_b)
      else $error("low level b not requested");

   a_level_agree: assert property (
      (st_ff.pin_lvl[0] != $past(st_ff.pin_lvl[0])) |->
      $past(st_ff.sync_a[1] == st_ff.sync_a[2]))
      else $error("level taken before stages agreed");

   a_wake_masked: assert property (
      wake_req |-> (st_ff.ext_irq_mask != 2'h0))
      else $error("wake with pins masked");

   a_vec_plain: assert property (
      (!st_ff.vector_select && vec_default_addr != 16'h0000) |=>
      (vec_addr == $past(vec_default_addr)))
      else $error("vector moved while select clear");

   a_fall_sets_flag: assert property (
      (st_ff.ext_irq_sense_ctrl[1:0] == 2'h2 && st_ff.pin_lvl[0] &&
       !new_lvl[0]) |=> st_ff.ext_irq_flags[0])
      else $error("falling edge missed on pin a");

   a_rise_sets_flag: assert property (
      (st_ff.ext_irq_sense_ctrl[1:0] == 2'h3 && !st_ff.pin_lvl[0] &&
       new_lvl[0]) |=> st_ff.ext_irq_flags[0])
      else $error("rising edge missed on pin a");

   a_rise_flag_b: assert property (
      (st_ff.ext_irq_sense_ctrl[3:2] == 2'h3 && !st_ff.pin_lvl[1] &&
       new_lvl[1]) |=> st_ff.ext_irq_flags[1])
      else $error("rising edge missed on pin b");

   a_mask_quiet: assert property (
      (!st_ff.ext_irq_mask[0] || !global_irq_en) |-> !irq_req_a)
      else $error("request a while disabled");

   a_wake_on_low: assert property (
      (st_ff.ext_irq_sense_ctrl[1:0] == 2'h0 && st_ff.ext_irq_mask[0] &&
       !ext_irq_pin_a) |-> wake_req)
      else $error("low pin a raised no wake");

   a_mcu_bits: assert property (
      (wr_acc && hit_mcu) |=>
      ({fast_wake_en, flash_powerdown_en, pullup_global_off} ==
       $past({pwdata[`EIVR_MCU_FASTWK], pwdata[`EIVR_MCU_FLASHPD],
              pwdata[`EIVR_MCU_PULLOFF]})))
      else $error("mcu control bits not written");

   a_flag_w1c: assert property (
      (wr_acc && hit_flags && pwdata[0] && !edge_hit[0]) |=>
      !st_ff.ext_irq_flags[0])
      else $error("write one left flag a set");

endmodule : eivr_top

// ==== dv/eivr_pin_src.sv ====
`timescale 1ns/1ps
// ====================
// sources on both pins; released pins sit at the pull-up level
module eivr_pin_src
(
   input  wire logic mclk,
   output logic      pin_a,
   output logic      pin_b
);
   initial
   begin
      pin_a = 1'b1;
      pin_b = 1'b1;
   end
   // a level is held whole cycles, so the sampler always sees it
   task automatic drive(input logic sel_b, input logic lvl, input int hold);
      @(posedge mclk);
      if (sel_b)
         pin_b <= lvl;
      else
         pin_a <= lvl;
      repeat (hold) @(posedge mclk);
   endtask : drive
endmodule : eivr_pin_src

// ==== dv/ext_irq_and_vector_relocation_tb_top.sv ====
`timescale 1ns/1ps
`include "eivr_cfg.svh"
// ====================
// bench for pin interrupts and vector relocation
module ext_irq_and_vector_relocation_tb_top;
   localparam logic [7:0] REGS [5] = '{`EIVR_IDX_MCU, `EIVR_IDX_FLAGS,
      `EIVR_IDX_MASK, `EIVR_IDX_SENSE, `EIVR_IDX_VBASE};
   logic        mclk, rst, psel, penable, pwrite, gie, ack_a, ack_b;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic        pready, pslverr, pin_a, pin_b, req_a, req_b, wake;
   logic [15:0] vdef, vaddr;
   logic        pu_off, fpd, fwk, serr;
   logic [7:0]  rd;
   int          err_count, samples_checked;

   eivr_pin_src src (.mclk(mclk), .pin_a(pin_a), .pin_b(pin_b));
   eivr_top uut (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .ext_irq_pin_a(pin_a),
      .ext_irq_pin_b(pin_b), .global_irq_en(gie), .irq_ack_a(ack_a),
      .irq_ack_b(ack_b), .irq_req_a(req_a), .irq_req_b(req_b),
      .wake_req(wake), .vec_default_addr(vdef), .vec_addr(vaddr),
      .pullup_global_off(pu_off), .flash_powerdown_en(fpd),
      .fast_wake_en(fwk));

   initial
   begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end

   // ====================
   // shared tasks
   task automatic stop_test;
      if (err_count == 0 && samples_checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : stop_test

   task automatic chk(input string what, input logic [15:0] exp,
                      input logic [15:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         err_count++;
         $display("CHECK FAILED %s exp %h got %h", what, exp, got);
      end
   endtask : chk

   task automatic wt(input int n);
      repeat (n) @(posedge mclk);
   endtask : wt

   // prdata holds until the next setup, so taking it at the edge is safe
   task automatic apb(input logic w, input logic [7:0] idx,
                      input logic [7:0] d);
      int n;
      @(posedge mclk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= {2'b00, idx, 2'b00};
      pwdata  <= {24'h0, d};
      @(posedge mclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge mclk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1)
      begin
         chk("pready", 16'h1, {15'h0, pready});
         stop_test;
      end
      rd = prdata[7:0];
      serr = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rchk(input string what, input logic [7:0] idx,
                       input logic [7:0] exp);
      apb(1'b0, idx, 8'h00);
      chk(what, {8'h0, exp}, {8'h0, rd});
   endtask : rchk

   // ====================
   // scenarios
   task automatic t_reset;
      foreach (REGS[i])
         rchk("reset value", REGS[i], 8'h00);
      apb(1'b0, 8'h40, 8'h00);
      chk("unmapped err", 16'h1, {15'h0, serr});
   endtask : t_reset

   task automatic t_regs;
      apb(1'b1, `EIVR_IDX_SENSE, 8'hff);
      rchk("sense", `EIVR_IDX_SENSE, 8'h0f);
      apb(1'b1, `EIVR_IDX_MASK, 8'hff);
      rchk("mask", `EIVR_IDX_MASK, 8'h03);
      apb(1'b1, `EIVR_IDX_MCU, 8'hd0);
      rchk("mcu", `EIVR_IDX_MCU, 8'hd0);
      chk("mcu pins", 16'h7, {13'h0, fwk, fpd, pu_off});
      apb(1'b1, `EIVR_IDX_MCU, 8'h00);
   endtask : t_regs

   task automatic t_vector;
      apb(1'b1, `EIVR_IDX_VBASE, 8'h12);
      vdef <= 16'h0004;
      wt(2);
      chk("vec plain", 16'h0004, vaddr);
      apb(1'b1, `EIVR_IDX_MCU, 8'h01);
      apb(1'b1, `EIVR_IDX_MCU, 8'h02);
      rchk("select set", `EIVR_IDX_MCU, 8'h02);
      wt(1);
      chk("vec moved", 16'h1204, vaddr);
      vdef <= 16'h0000;
      wt(2);
      chk("reset vec", 16'h0000, vaddr);
      apb(1'b1, `EIVR_IDX_MCU, 8'h01);
      wt(8);
      apb(1'b1, `EIVR_IDX_MCU, 8'h00);
      rchk("late select", `EIVR_IDX_MCU, 8'h02);
   endtask : t_vector

   // waits of 8 cycles cover the three-flop sampler on the pins
   task automatic t_edges;
      for (int c = 1; c < 4; c++)
      begin
         apb(1'b1, `EIVR_IDX_SENSE, 8'(c));
         apb(1'b1, `EIVR_IDX_FLAGS, 8'h03);
         src.drive(1'b0, 1'b0, 8);
         rchk("fall", `EIVR_IDX_FLAGS, {7'h0, c != 3});
         apb(1'b1, `EIVR_IDX_FLAGS, 8'h03);
         src.drive(1'b0, 1'b1, 8);
         rchk("rise", `EIVR_IDX_FLAGS, {7'h0, c != 2});
      end
      apb(1'b1, `EIVR_IDX_FLAGS, 8'h03);
      src.drive(1'b0, 1'b0, 2);
      src.drive(1'b0, 1'b1, 8);
      rchk("short pulse", `EIVR_IDX_FLAGS, 8'h01);
      ack_a <= 1'b1;
      wt(1);
      ack_a <= 1'b0;
      rchk("ack a clr", `EIVR_IDX_FLAGS, 8'h00);
      apb(1'b1, `EIVR_IDX_SENSE, 8'h0c);
      apb(1'b1, `EIVR_IDX_FLAGS, 8'h03);
      src.drive(1'b1, 1'b0, 8);
      src.drive(1'b1, 1'b1, 8);
      rchk("pin b", `EIVR_IDX_FLAGS, 8'h02);
      chk("req b", 16'h1, {15'h0, req_b});
      gie <= 1'b0;
      wt(2);
      chk("req b off", 16'h0, {15'h0, req_b});
      gie <= 1'b1;
      ack_b <= 1'b1;
      wt(1);
      ack_b <= 1'b0;
      rchk("ack clr", `EIVR_IDX_FLAGS, 8'h00);
   endtask : t_edges

   task automatic t_level;
      apb(1'b1, `EIVR_IDX_SENSE, 8'h00);
      src.drive(1'b0, 1'b0, 8);
      chk("lvl req", 16'h1, {15'h0, req_a});
      chk("lvl wake", 16'h1, {15'h0, wake});
      rchk("lvl flag", `EIVR_IDX_FLAGS, 8'h00);
      apb(1'b1, `EIVR_IDX_MASK, 8'h02);
      wt(1);
      chk("masked", 16'h0, {14'h0, wake, req_a});
      apb(1'b1, `EIVR_IDX_MASK, 8'h03);
      src.drive(1'b0, 1'b1, 8);
      chk("lvl gone", 16'h0, {15'h0, req_a});
      src.drive(1'b1, 1'b0, 8);
      chk("lvl req b", 16'h1, {15'h0, req_b});
      src.drive(1'b1, 1'b1, 8);
      chk("lvl gone b", 16'h0, {15'h0, req_b});
   endtask : t_level

   initial
   begin
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      gie = 1'b1;
      ack_a = 1'b0;
      ack_b = 1'b0;
      vdef = 16'h0000;
      err_count = 0;
      samples_checked = 0;
      wt(12);
      rst <= 1'b0;
      t_reset;
      t_regs;
      t_vector;
      t_edges;
      t_level;
      stop_test;
   end
endmodule : ext_irq_and_vector_relocation_tb_top
